// file: include/aso_pkg.sv
// aso_pkg: constants and carrier types of the serial converter output side.
// assumes one 125 MHz core clock samples every link pin; no register bus.
//
// Function
// (R1) unipolar result is 12-bit straight binary
// (R2) bipolar result is 12-bit two's complement
// (R3) order bit one: shift result MSB first
// (R4) MSB-first mode: zeros after last bit forever
// (R5) order bit zero: MSB first, then LSB first
// (R6) bipolar with order zero: sign bit fills after MSB
// (R7) shutdown bit zero in input word: power down
// (R8) shutdown with select held: twelve ones, then zeros
// (R9) select released after shutdown: output goes high-impedance
// (R10) shutdown lasts until next select cycle begins
// (R11) first cycle after shutdown converts without wait
// (R12) halt output driven low on shutdown
// (R13) halt output returns high at next select cycle
// (R14) host may bit-bang the link on port lines
// (R15) leading zeros ignored; first one is start bit
// (R16) polarity bit one unipolar, zero bipolar
// (R17) start, seven config bits, null bit, then result
// (R18) host raises select after each exchange to reset
// (R19) out-of-span inputs saturate to end codes
// (R20) output high-impedance whenever select is high
package aso_pkg;

  localparam int ASO_RES_BITS    = 12;
  localparam int ASO_CFG_BITS    = 7;
  localparam int ASO_FIFO_DEPTH  = 16;
  localparam int ASO_SYNC_STAGES = 3;

  // output sequence positions, counted in falling link-clock edges after the config word
  localparam logic [4:0] ASO_IDX_NULL     = 5'h00;
  localparam logic [4:0] ASO_IDX_MSB_LAST = 5'h0C;
  localparam logic [4:0] ASO_IDX_LSB_LAST = 5'h17;
  localparam logic [4:0] ASO_IDX_FILL     = 5'h18;
  localparam logic [2:0] ASO_CFG_LAST     = 3'h6;

  // end codes of the two formats
  localparam logic [11:0] ASO_UNI_MAX = 12'hFFF;
  localparam logic [11:0] ASO_UNI_MIN = 12'h000;
  localparam logic [11:0] ASO_BIP_MAX = 12'h7FF;
  localparam logic [11:0] ASO_BIP_MIN = 12'h800;

  // reset values
  localparam logic [11:0] ASO_RESULT_RST = 12'h000;
  localparam logic        ASO_DOUT_RST   = 1'b0;
  localparam logic [2:0]  ASO_PIN_RST    = 3'h1;

  // pin vector positions
  localparam int ASO_PIN_CS   = 0;
  localparam int ASO_PIN_SCLK = 1;
  localparam int ASO_PIN_DIN  = 2;

  typedef enum logic [1:0] {
    ASO_ST_IDLE = 2'b00,
    ASO_ST_HUNT = 2'b01,
    ASO_ST_CFG  = 2'b10,
    ASO_ST_OUT  = 2'b11
  } aso_state_t;

  // config word, first received bit at the top
  typedef struct packed {
    logic       single_ended;
    logic       odd_sign;
    logic [1:0] mux_select;
    logic       polarity_select;
    logic       output_order_select;
    logic       shutdown_select_n;
  } aso_cfg_t;

  // sample from the front end: offset-binary code over the span plus range flags
  typedef struct packed {
    logic        over_range;
    logic        under_range;
    logic [11:0] code;
  } aso_sample_t;

endpackage

// file: tb/aso_host_model.sv
// aso_host_model: port-line host driving the four-wire link.
// assumes a 125 ns link clock that idles low outside frames.
`timescale 1ns/1ns
module aso_host_model (
  // link pins
  output logic        cs_n_pin,
  output logic        sclk_pin,
  output logic        din_pin,
  input  wire logic   dout_pin,
  input  wire logic   dout_oe,
  // captured reply
  output logic [25:0] rx_bits,
  output logic        rx_done
);
  logic last_q;
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    din_pin  = 1'b0;
    rx_bits  = '0;
    rx_done  = 1'b0;
    last_q   = 1'b0;
  end
  ////////////////////////////////
  // undriven wire reads as inverse of last bit, never a lucky match
  task automatic tick(input logic d, output logic q);
    din_pin = d;
    #62 sclk_pin = 1'b1;
    q = dout_oe ? dout_pin : ~last_q;
    last_q = q;
    #63 sclk_pin = 1'b0;
  endtask
  task automatic frame(input logic [6:0] cfg);
    logic q;
    cs_n_pin = 1'b0;
    #200;
    repeat (2) tick(1'b0, q);
    tick(1'b1, q);
    for (int i = 6; i >= 0; i--) tick(cfg[i], q);
    for (int i = 25; i >= 0; i--) begin
      tick(i[0], q);
      rx_bits[i] = q;
    end
    #100 cs_n_pin = 1'b1;
    din_pin = ~din_pin;
    rx_done = 1'b1;
    #200 rx_done = 1'b0;
  endtask
endmodule

// file: tb/aso_serial_core_props.sv
// aso_serial_core_props: port properties of the serial core.
// assumes bind onto aso_serial_core; link pins far slower than ref_clk.
`timescale 1ns/1ns
module aso_serial_core_props import aso_pkg::*; #(
  parameter int RES_BITS   = ASO_RES_BITS,
  parameter int FIFO_DEPTH = ASO_FIFO_DEPTH
) (
  // clock and reset
  input wire logic     ref_clk,
  input wire logic     sys_rst,
  // link pins
  input wire logic     cs_n_pin,
  input wire logic     sclk_pin,
  input wire logic     dout_pin,
  input wire logic     dout_oe,
  // control outputs
  input wire aso_cfg_t cfg_out,
  input wire logic     conv_start,
  input wire logic     result_missing,
  input wire logic     power_down,
  input wire logic     system_halt_out_n
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////
  // seven samples: sync plus register latency with one cycle of slack
  AST_OE_IDLE: assert property (cs_n_pin [*7] |-> !dout_oe)
    else $error("dout driven while select high");
  AST_NULL_BIT: assert property ($rose(dout_oe) |-> !dout_pin && !cs_n_pin)
    else $error("first driven bit not null");
  AST_OE_DROP: assert property ($fell(dout_oe) |-> cs_n_pin && $past(cs_n_pin, 3))
    else $error("dout released while selected");
  AST_DOUT_HOLD: assert property ($changed(dout_pin) && dout_oe |-> !$past(sclk_pin, 3))
    else $error("dout moved away from a link clock fall");
  AST_HALT_PAIR: assert property (power_down != system_halt_out_n)
    else $error("halt output disagrees with power state");
  AST_HALT_CAUSE: assert property ($fell(system_halt_out_n) |->
    ##[0:2] !cfg_out.shutdown_select_n)
    else $error("halt without shutdown word");
  AST_WAKE: assert property ($rose(system_halt_out_n) |->
    !cs_n_pin && !$past(cs_n_pin, 3))
    else $error("halt released without select cycle");
  AST_CONV_CFG: assert property (conv_start |-> ##[0:1] cfg_out.shutdown_select_n)
    else $error("conversion on shutdown word");
  AST_CONV_PULSE: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  AST_MISS_PAIR: assert property (result_missing |->
    conv_start && cfg_out.shutdown_select_n)
    else $error("missing result flag without a conversion");
endmodule

bind aso_serial_core aso_serial_core_props #(.RES_BITS(RES_BITS), .FIFO_DEPTH(FIFO_DEPTH))
  u_aso_serial_core_props (.ref_clk, .sys_rst, .cs_n_pin, .sclk_pin, .dout_pin, .dout_oe,
  .cfg_out, .conv_start, .result_missing, .power_down, .system_halt_out_n);

// file: tb/test_adc_serial_output_format_shutdown.sv
// test_adc_serial_output_format_shutdown: frames in every format and shutdown.
// assumes default core parameters and the host model on the link.
`timescale 1ns/1ns
module test_adc_serial_output_format_shutdown import aso_pkg::*; ();
  logic        ref_clk, sys_rst, cs_n_pin, sclk_pin, din_pin, dout_pin, dout_oe;
  logic        smp_valid, smp_ready, conv_start, result_missing, power_down;
  logic        system_halt_out_n, rx_done;
  aso_sample_t smp_data;
  aso_cfg_t    cfg_out;
  logic [25:0] rx_bits;
  logic [31:0] rng;
  int          err_total, check_count;
  int          conv_cnt, miss_cnt, exp_conv, exp_miss;
  logic [25:0] exp_q[$];
  aso_sample_t smp_q[$];

  aso_serial_core u_aso_serial_core (.ref_clk, .sys_rst, .cs_n_pin, .sclk_pin, .din_pin,
    .dout_pin, .dout_oe, .smp_valid, .smp_ready, .smp_data, .cfg_out, .conv_start,
    .result_missing, .power_down, .system_halt_out_n);
  aso_host_model u_aso_host_model (.cs_n_pin, .sclk_pin, .din_pin, .dout_pin, .dout_oe,
    .rx_bits, .rx_done);
  ////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic logic [25:0] want(input logic [6:0] cfg, input aso_sample_t s,
                                       input logic miss);
    logic [11:0] r;
    logic [25:0] b;
    if (cfg[2])
      r = s.over_range ? 12'hfff : (s.under_range ? 12'h000 : s.code);
    else
      r = s.over_range ? 12'h7ff : (s.under_range ? 12'h800 : s.code ^ 12'h800);
    if (miss)
      r = 12'h000;
    b = {1'b0, r, 13'h0};
    if (!cfg[1]) begin
      for (int i = 1; i < 12; i++)
        b[13 - i] = r[i];
      b[1:0] = cfg[2] ? 2'b00 : {2{r[11]}};
    end
    if (!cfg[0])
      b = {1'b0, 12'hfff, 13'h0};
    return b;
  endfunction

  task automatic chk(input string what, input logic [25:0] exp, input logic [25:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge rx_done)
    chk("dout frame", exp_q.pop_front(), rx_bits);

  // single-cycle pulses, counted away from the launching edge
  always @(negedge ref_clk) begin
    if (conv_start === 1'b1)
      conv_cnt++;
    if (result_missing === 1'b1)
      miss_cnt++;
  end

  // whole run is about 110 us of link traffic
  initial begin
    #400_000;
    err_total++;
    summarize();
  end

  initial begin
    logic [6:0]  cfg;
    aso_sample_t s;
    logic        miss;
    err_total   = 0;
    check_count = 0;
    rng         = 32'hd348_1db2;
    sys_rst     = 1'b1;
    smp_valid   = 1'b0;
    smp_data    = '0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    chk("reset outputs", 26'h5,
        26'({cfg_out, power_down, system_halt_out_n, dout_oe, smp_ready}));
    // one push too many: the seventeenth must be refused
    for (int i = 0; i < 17; i++) begin
      rng       = xs(rng);
      smp_data  = {rng[31:29] == 3'h0, rng[28:26] == 3'h0, rng[11:0]};
      smp_valid = 1'b1;
      if (smp_ready)
        smp_q.push_back(smp_data);
      @(negedge ref_clk);
    end
    smp_valid = 1'b0;
    chk("smp_ready full", 26'h0, 26'(smp_ready));
    // sixteen conversions drain the buffer, frame 20 finds it empty
    for (int i = 0; i < 22; i++) begin
      rng  = xs(rng);
      cfg  = {rng[6:3], i[0], i[1], i % 5 != 3};
      miss = cfg[0] && smp_q.size() == 0;
      s    = (cfg[0] && !miss) ? smp_q.pop_front() : '0;
      exp_q.push_back(want(cfg, s, miss));
      exp_conv += int'(cfg[0]);
      exp_miss += int'(miss);
      u_aso_host_model.frame(cfg);
      chk("power state", 26'({!cfg[0], cfg[0], 1'b0}),
          26'({power_down, system_halt_out_n, dout_oe}));
      chk("cfg_out", 26'(cfg), 26'(cfg_out));
      chk("conv_start count", 26'(exp_conv), 26'(conv_cnt));
      chk("result_missing count", 26'(exp_miss), 26'(miss_cnt));
      if (i == 20) begin
        chk("smp_ready drained", 26'h1, 26'(smp_ready));
        // step off the edge at which the frame ended before driving
        @(posedge ref_clk);
        @(negedge ref_clk);
        smp_data  = rng[13:0];
        smp_valid = 1'b1;
        smp_q.push_back(smp_data);
        @(negedge ref_clk);
        smp_valid = 1'b0;
      end
    end
    #100;
    summarize();
  end
endmodule

// file: verilog/aso_fifo.sv
// aso_fifo: flip-flop FIFO between the sample source and the serial engine.
// assumes both sides on ref_clk; valid/ready handshake on each side.
`timescale 1ns/1ns
module aso_fifo import aso_pkg::*; #(
  parameter int WIDTH = 14,
  parameter int DEPTH = ASO_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  // drain side
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign wr_ready = (count_q != (AW+1)'(DEPTH));
  assign rd_valid = (count_q != '0);
  assign rd_data  = mem_q[rd_ptr_q];
  assign push     = wr_valid & wr_ready;
  assign pop      = rd_valid & rd_ready;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + (AW+1)'(1);
      end else if (pop && !push) begin
        count_q <= count_q - (AW+1)'(1);
      end
    end
  end

endmodule

// file: verilog/aso_serial_core.sv
// aso_serial_core: device side of the four-wire serial converter link.
// assumes link pins asynchronous to ref_clk and much slower than it;
// the pad merges dout_pin/dout_oe onto the wire outside this module.
`timescale 1ns/1ns
module aso_serial_core import aso_pkg::*; #(
  parameter int RES_BITS   = ASO_RES_BITS,
  parameter int FIFO_DEPTH = ASO_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // link pins
  input  wire logic        cs_n_pin,
  input  wire logic        sclk_pin,
  input  wire logic        din_pin,
  output logic             dout_pin,
  output logic             dout_oe,
  // sample source
  input  wire logic        smp_valid,
  output logic             smp_ready,
  input  wire aso_sample_t smp_data,
  // conversion and power control
  output aso_cfg_t         cfg_out,
  output logic             conv_start,
  output logic             result_missing,
  output logic             power_down,
  output logic             system_halt_out_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, a change counts when stages two and three agree

  logic [2:0] pin_raw;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] pin_q;
  logic [2:0] pin_prev_q;

  assign pin_raw = {din_pin, sclk_pin, cs_n_pin};

  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        sync1_q[i]    <= ASO_PIN_RST[i];
        sync2_q[i]    <= ASO_PIN_RST[i];
        sync3_q[i]    <= ASO_PIN_RST[i];
        pin_q[i]      <= ASO_PIN_RST[i];
        pin_prev_q[i] <= ASO_PIN_RST[i];
      end else begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
        sync3_q[i] <= sync2_q[i];
        if (sync2_q[i] == sync3_q[i]) begin
          pin_q[i] <= sync3_q[i];
        end
        pin_prev_q[i] <= pin_q[i];
      end
    end
  end

  // edge pulses last one cycle; host levels must hold three cycles
  logic cs_high;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic din_s;

  assign cs_high   = pin_q[ASO_PIN_CS];
  assign cs_fall   = ~pin_q[ASO_PIN_CS] & pin_prev_q[ASO_PIN_CS];
  assign sclk_rise = pin_q[ASO_PIN_SCLK] & ~pin_prev_q[ASO_PIN_SCLK];
  assign sclk_fall = ~pin_q[ASO_PIN_SCLK] & pin_prev_q[ASO_PIN_SCLK];
  assign din_s     = pin_q[ASO_PIN_DIN];

  ////////////////////////////////////////////////////////////////////////////////
  // sample buffer

  aso_sample_t fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;

  aso_fifo #(
    .WIDTH ($bits(aso_sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .wr_valid (smp_valid),
    .wr_ready (smp_ready),
    .wr_data  (smp_data),
    .rd_valid (fifo_valid),
    .rd_ready (fifo_pop),
    .rd_data  (fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // input word framing

  aso_state_t state_q;
  logic [2:0] cfg_cnt_q;
  logic [ASO_CFG_BITS-1:0] cfg_sh_q;
  logic       cfg_done;
  aso_cfg_t   cfg_new;

  assign cfg_done = (state_q == ASO_ST_CFG) && sclk_rise && (cfg_cnt_q == ASO_CFG_LAST);
  assign cfg_new  = aso_cfg_t'({cfg_sh_q[ASO_CFG_BITS-2:0], din_s});

  // a result is taken only when a real conversion is requested
  assign fifo_pop = cfg_done & cfg_new.shutdown_select_n;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ASO_ST_IDLE;
    end else if (cs_high) begin
      state_q <= ASO_ST_IDLE; // (R18) (R20)
    end else begin
      unique case (state_q)
        ASO_ST_IDLE: begin
          if (cs_fall) begin
            state_q <= ASO_ST_HUNT;
          end
        end
        ASO_ST_HUNT: begin
          if (sclk_rise && din_s) begin
            state_q <= ASO_ST_CFG; // (R15)
          end
        end
        ASO_ST_CFG: begin
          if (cfg_done) begin
            state_q <= ASO_ST_OUT; // (R17)
          end
        end
        ASO_ST_OUT: begin
          state_q <= ASO_ST_OUT;
        end
      endcase
    end
  end

  // counter restarts in hunt, so a cut frame leaves nothing behind
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_cnt_q <= '0;
      cfg_sh_q  <= '0;
    end else if (state_q == ASO_ST_HUNT) begin
      cfg_cnt_q <= '0;
    end else if (state_q == ASO_ST_CFG && sclk_rise) begin
      cfg_sh_q  <= {cfg_sh_q[ASO_CFG_BITS-2:0], din_s}; // (R17)
      cfg_cnt_q <= cfg_cnt_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // conversion result capture and code formatting

  function automatic logic [11:0] fmt_code(aso_sample_t s, logic unipolar);
    logic [11:0] c;
    c = s.code;
    if (unipolar) begin // (R16)
      if (s.over_range) begin
        c = ASO_UNI_MAX; // (R19)
      end else if (s.under_range) begin
        c = ASO_UNI_MIN; // (R19)
      end else begin
        c = s.code; // (R1)
      end
    end else begin
      if (s.over_range) begin
        c = ASO_BIP_MAX;
      end else if (s.under_range) begin
        c = ASO_BIP_MIN;
      end else begin
        c = {~s.code[11], s.code[10:0]}; // (R2)
      end
    end
    return c;
  endfunction

  logic [11:0] result_q;
  aso_cfg_t    cfg_q;
  logic        conv_start_q;
  logic        missing_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= '0;
    end else if (cfg_done) begin
      cfg_q <= cfg_new; // (R16)
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_start_q <= 1'b0;
      missing_q    <= 1'b0;
    end else begin
      conv_start_q <= fifo_pop; // (R11)
      missing_q    <= fifo_pop & ~fifo_valid;
    end
  end

  // an empty buffer still answers the host, with a zero code and a flag
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_q <= ASO_RESULT_RST;
    end else if (fifo_pop) begin
      result_q <= fifo_valid ? fmt_code(fifo_data, cfg_new.polarity_select)
                             : ASO_RESULT_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power shutdown and halt output

  logic shut_seq_q;
  logic power_down_q;
  logic halt_n_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shut_seq_q   <= 1'b0;
      power_down_q <= 1'b0;
      halt_n_q     <= 1'b1;
    end else if (cfg_done && !cfg_new.shutdown_select_n) begin
      shut_seq_q   <= 1'b1;
      power_down_q <= 1'b1; // (R7)
      halt_n_q     <= 1'b0; // (R12)
    end else if (cs_fall) begin
      shut_seq_q   <= 1'b0;
      power_down_q <= 1'b0; // (R10) (R11)
      halt_n_q     <= 1'b1; // (R13)
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output sequencer, updated on falling link-clock edges

  logic [4:0] idx_q;
  logic       drv_q;
  logic       dout_q;
  logic [4:0] idx_nxt;
  logic       bit_nxt;
  logic [4:0] msb_pos;
  logic [4:0] lsb_pos;

  // the index saturates on the fill slot, so long host words never wrap
  always_comb begin
    idx_nxt = ASO_IDX_NULL;
    if (drv_q) begin
      idx_nxt = (idx_q == ASO_IDX_FILL) ? ASO_IDX_FILL : idx_q + 5'h01;
    end
  end

  assign msb_pos = ASO_IDX_MSB_LAST - idx_nxt;
  assign lsb_pos = idx_nxt - ASO_IDX_MSB_LAST;

  always_comb begin
    bit_nxt = 1'b0;
    if (idx_nxt == ASO_IDX_NULL) begin
      bit_nxt = 1'b0; // (R17)
    end else if (shut_seq_q) begin
      bit_nxt = (idx_nxt <= ASO_IDX_MSB_LAST); // (R8)
    end else if (idx_nxt <= ASO_IDX_MSB_LAST) begin
      bit_nxt = result_q[msb_pos[3:0]]; // (R3)
    end else if (!cfg_q.output_order_select && idx_nxt <= ASO_IDX_LSB_LAST) begin
      bit_nxt = result_q[lsb_pos[3:0]]; // (R5)
    end else if (!cfg_q.output_order_select && !cfg_q.polarity_select) begin
      bit_nxt = result_q[11]; // (R6)
    end else begin
      bit_nxt = 1'b0; // (R4)
    end
  end

  // drive stops as soon as select is seen high, in every mode
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx_q  <= ASO_IDX_NULL;
      drv_q  <= 1'b0;
      dout_q <= ASO_DOUT_RST;
    end else if (cs_high || state_q != ASO_ST_OUT) begin
      idx_q  <= ASO_IDX_NULL;
      drv_q  <= 1'b0; // (R9) (R20)
      dout_q <= ASO_DOUT_RST;
    end else if (sclk_fall) begin
      idx_q  <= idx_nxt;
      drv_q  <= 1'b1;
      dout_q <= bit_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign dout_pin          = dout_q;
  assign dout_oe           = drv_q;
  assign cfg_out           = cfg_q;
  assign conv_start        = conv_start_q;
  assign result_missing    = missing_q;
  assign power_down        = power_down_q;
  assign system_halt_out_n = halt_n_q;

endmodule
